// *** cta_pkg.sv ***
// Constants and types for the pack-current threshold alert block.
// Assumes an AXI4-Lite master with 32-bit data and 12-bit addresses.
package cta_pkg;

  // ----------------------------------------
  // Register indexes, byte address = 4 * index
  // ----------------------------------------
  localparam logic [9:0] IDX_OV_CLR = 10'h02c;
  localparam logic [9:0] IDX_OV_SET = 10'h02d;
  localparam logic [9:0] IDX_UV_CLR = 10'h02e;
  localparam logic [9:0] IDX_UV_SET = 10'h02f;
  localparam logic [9:0] IDX_STATUS = 10'h040;
  localparam logic [9:0] IDX_MASK = 10'h041;
  localparam logic [9:0] IDX_ALERT = 10'h042;

  // ----------------------------------------
  // Codes, reset values and answers
  // ----------------------------------------
  localparam logic [13:0] CODE_ZERO = 14'h2000;
  localparam logic [13:0] OV_THR_RESET = 14'h3fff;
  localparam logic [13:0] UV_THR_RESET = 14'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned STAT_CHG_BIT = 0;
  localparam int unsigned STAT_DIS_BIT = 1;

  // ----------------------------------------
  // Channel states, Gray coded
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RESP = 2'h1} cta_state_type;

  typedef struct packed {
    cta_state_type wst;
    cta_state_type rst;
    logic aw_got;
    logic w_got;
    logic [9:0] aw_idx;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic [1:0] bresp;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [13:0] ov_clr;
    logic [13:0] ov_set;
    logic [13:0] uv_clr;
    logic [13:0] uv_set;
    logic chg;
    logic dis;
    logic charging;
    logic discharging;
    logic [1:0] status;
    logic [1:0] mask;
  } cta_regs_type;

  localparam cta_regs_type REGS_RESET = '{
    wst: ST_IDLE, rst: ST_IDLE, aw_got: 1'b0, w_got: 1'b0, aw_idx: 10'h000,
    wdata: 16'h0000, wstrb: 2'h0, bresp: RESP_OKAY, rdata: 16'h0000,
    rresp: RESP_OKAY, ov_clr: OV_THR_RESET, ov_set: OV_THR_RESET,
    uv_clr: UV_THR_RESET, uv_set: UV_THR_RESET, chg: 1'b0, dis: 1'b0,
    charging: 1'b0, discharging: 1'b0, status: 2'h0, mask: 2'h0};

endpackage

// *** cta_top.sv ***
// Pack-current threshold alerts with an AXI4-Lite register slave.
// Assumes current codes arrive already converted bipolar with gain applied.
//
// How it works
// - Charge alert rises when a code is strictly above the over set value.
// - Charge alert falls when a code is at or below the over clear value.
// - Discharge alert rises when a code is strictly below the under set value.
// - Discharge alert falls when a code is at or above the under clear value.
// - Codes are bipolar: midscale is zero, below discharges, above charges.
// - Compared codes are bipolar current-sense results with gain applied.
// - Over set value of all ones can never raise the charge alert.
// - Under set value of zero can never raise the discharge alert.
// - Each threshold is 14 bits in register bits 15:2; bits 1:0 empty.
// - All four thresholds are read/write and read back the last write.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps

module cta_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Current measurement
  input wire logic CUR_VALID,
  input wire logic [13:0] CUR_CODE,
  // Alerts
  output logic CHARGE_CURRENT_ALERT,
  output logic DISCHARGE_CURRENT_ALERT,
  output logic IRQ,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [11:0] AWADDR,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [11:0] ARADDR,
  // AXI4-Lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP
);

  // ----------------------------------------
  // State and strobes
  // ----------------------------------------
  cta_pkg::cta_regs_type s_q;
  cta_pkg::cta_regs_type s_d;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic [1:0] clr_bits;
  logic [1:0] events;

  // Byte-lane merge into a threshold held in bits 15:2
  function automatic logic [13:0] wr_thr(
    input logic [13:0] old,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    logic [13:0] v;
    v = old;
    if (strb[0])
    begin
      v[5:0] = data[7:2];
    end
    if (strb[1])
    begin
      v[13:6] = data[15:8];
    end
    return v;
  endfunction

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  // One write and one read in flight; ready drops while a response waits
  assign AWREADY = (s_q.wst == cta_pkg::ST_IDLE) && !s_q.aw_got;
  assign WREADY = (s_q.wst == cta_pkg::ST_IDLE) && !s_q.w_got;
  assign ARREADY = (s_q.rst == cta_pkg::ST_IDLE);
  assign aw_take = AWVALID && AWREADY;
  assign w_take = WVALID && WREADY;
  assign ar_take = ARVALID && ARREADY;

  // Outputs built from flops alone, with no input in the path
  assign BVALID = (s_q.wst == cta_pkg::ST_RESP);
  assign BRESP = s_q.bresp;
  assign RVALID = (s_q.rst == cta_pkg::ST_RESP);
  assign RDATA = {16'h0000, s_q.rdata};
  assign RRESP = s_q.rresp;
  assign CHARGE_CURRENT_ALERT = s_q.chg;
  assign DISCHARGE_CURRENT_ALERT = s_q.dis;
  assign IRQ = |(s_q.status & s_q.mask);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    wr_go = 1'b0;
    clr_bits = 2'h0;
    events = 2'h0;
    // Address and data may come in either order
    if (aw_take)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = AWADDR[11:2];
    end
    if (w_take)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = WDATA[15:0];
      s_d.wstrb = WSTRB[1:0];
    end
    if (s_d.aw_got && s_d.w_got)
    begin
      wr_go = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.wst = cta_pkg::ST_RESP;
      s_d.bresp = cta_pkg::RESP_OKAY;
      case (s_d.aw_idx)
        cta_pkg::IDX_OV_CLR:
        begin
          s_d.ov_clr = wr_thr(s_q.ov_clr, s_d.wdata, s_d.wstrb);
        end
        cta_pkg::IDX_OV_SET:
        begin
          s_d.ov_set = wr_thr(s_q.ov_set, s_d.wdata, s_d.wstrb);
        end
        cta_pkg::IDX_UV_CLR:
        begin
          s_d.uv_clr = wr_thr(s_q.uv_clr, s_d.wdata, s_d.wstrb);
        end
        cta_pkg::IDX_UV_SET:
        begin
          s_d.uv_set = wr_thr(s_q.uv_set, s_d.wdata, s_d.wstrb);
        end
        cta_pkg::IDX_STATUS:
        begin
          if (s_d.wstrb[0])
          begin
            clr_bits = s_d.wdata[1:0];
          end
        end
        cta_pkg::IDX_MASK:
        begin
          if (s_d.wstrb[0])
          begin
            s_d.mask = s_d.wdata[1:0];
          end
        end
        cta_pkg::IDX_ALERT:
        begin
          s_d.bresp = cta_pkg::RESP_OKAY; // Read-only, write dropped
        end
        default:
        begin
          s_d.bresp = cta_pkg::RESP_SLVERR;
        end
      endcase
    end
    if ((s_q.wst == cta_pkg::ST_RESP) && BREADY)
    begin
      s_d.wst = cta_pkg::ST_IDLE;
    end
    // Read data is captured at address time
    if (ar_take)
    begin
      s_d.rst = cta_pkg::ST_RESP;
      s_d.rresp = cta_pkg::RESP_OKAY;
      case (ARADDR[11:2])
        cta_pkg::IDX_OV_CLR:
        begin
          s_d.rdata = {s_q.ov_clr, 2'h0};
        end
        cta_pkg::IDX_OV_SET:
        begin
          s_d.rdata = {s_q.ov_set, 2'h0};
        end
        cta_pkg::IDX_UV_CLR:
        begin
          s_d.rdata = {s_q.uv_clr, 2'h0};
        end
        cta_pkg::IDX_UV_SET:
        begin
          s_d.rdata = {s_q.uv_set, 2'h0};
        end
        cta_pkg::IDX_STATUS:
        begin
          s_d.rdata = {14'h0000, s_q.status};
        end
        cta_pkg::IDX_MASK:
        begin
          s_d.rdata = {14'h0000, s_q.mask};
        end
        cta_pkg::IDX_ALERT:
        begin
          s_d.rdata = {12'h000, s_q.discharging, s_q.charging, s_q.dis, s_q.chg};
        end
        default:
        begin
          s_d.rdata = 16'h0000;
          s_d.rresp = cta_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if ((s_q.rst == cta_pkg::ST_RESP) && RREADY)
    begin
      s_d.rst = cta_pkg::ST_IDLE;
    end
    // Hysteretic compare; set wins if software mis-orders the pair
    if (CUR_VALID)
    begin
      if (CUR_CODE > s_q.ov_set)
      begin
        s_d.chg = 1'b1;
      end
      else if (CUR_CODE <= s_q.ov_clr)
      begin
        s_d.chg = 1'b0;
      end
      if (CUR_CODE < s_q.uv_set)
      begin
        s_d.dis = 1'b1;
      end
      else if (CUR_CODE >= s_q.uv_clr)
      begin
        s_d.dis = 1'b0;
      end
      s_d.charging = (CUR_CODE > cta_pkg::CODE_ZERO);
      s_d.discharging = (CUR_CODE < cta_pkg::CODE_ZERO);
    end
    // Rising alerts are sticky; a new event beats a same-cycle clear
    events[cta_pkg::STAT_CHG_BIT] = s_d.chg && !s_q.chg;
    events[cta_pkg::STAT_DIS_BIT] = s_d.dis && !s_q.dis;
    s_d.status = (s_q.status & ~clr_bits) | events;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s_q <= cta_pkg::REGS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_over_set:
  assert property (CUR_VALID && (CUR_CODE > s_q.ov_set) |=> CHARGE_CURRENT_ALERT)
  else $error("charge alert missed above set");

  a_over_clear:
  assert property (CUR_VALID && (CUR_CODE <= s_q.ov_clr) && (CUR_CODE <= s_q.ov_set)
    |=> !CHARGE_CURRENT_ALERT)
  else $error("charge alert not cleared");

  a_under_set:
  assert property (CUR_VALID && (CUR_CODE < s_q.uv_set) |=> DISCHARGE_CURRENT_ALERT)
  else $error("discharge alert missed below set");

  a_under_clear:
  assert property (CUR_VALID && (CUR_CODE >= s_q.uv_clr) && (CUR_CODE >= s_q.uv_set)
    |=> !DISCHARGE_CURRENT_ALERT)
  else $error("discharge alert not cleared");

  a_zero_code:
  assert property (CUR_VALID && (CUR_CODE == cta_pkg::CODE_ZERO)
    |=> !s_q.charging && !s_q.discharging)
  else $error("midscale not treated as zero");

  a_over_off:
  assert property ((s_q.ov_set == cta_pkg::OV_THR_RESET) && !CHARGE_CURRENT_ALERT
    |=> !CHARGE_CURRENT_ALERT)
  else $error("charge alert with checking off");

  a_under_off:
  assert property ((s_q.uv_set == cta_pkg::UV_THR_RESET) && !DISCHARGE_CURRENT_ALERT
    |=> !DISCHARGE_CURRENT_ALERT)
  else $error("discharge alert with checking off");

  a_low_bits:
  assert property (ar_take && (ARADDR[11:2] >= cta_pkg::IDX_OV_CLR) && (ARADDR[11:2] <= cta_pkg::IDX_UV_SET)
    |=> RVALID && (RDATA[1:0] == 2'h0) && (RDATA[31:16] == 16'h0000))
  else $error("bits above or below field not zero");

  a_thr_write:
  assert property (wr_go && (s_d.aw_idx == cta_pkg::IDX_OV_SET) && (s_d.wstrb == 2'h3)
    |=> s_q.ov_set == $past(s_d.wdata[15:2]))
  else $error("threshold write not stored");

  a_alert_hold:
  assert property (!CUR_VALID |=> $stable(CHARGE_CURRENT_ALERT) && $stable(DISCHARGE_CURRENT_ALERT))
  else $error("alert moved without a code");

endmodule

// *** tb.sv ***
// Self-checking bench for the pack-current threshold alert block.
// Assumes cta_pkg and cta_top are compiled first; single 50 MHz clock.
`timescale 1ns/100ps

module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cur_valid = 1'b0;
  logic [13:0] cur_code = 14'h2000;
  logic chg, dis, irq, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int num_errors = 0;
  int check_count = 0;
  localparam logic [11:0] A_OC = {cta_pkg::IDX_OV_CLR, 2'b00};
  localparam logic [11:0] A_OS = {cta_pkg::IDX_OV_SET, 2'b00};
  localparam logic [11:0] A_UC = {cta_pkg::IDX_UV_CLR, 2'b00};
  localparam logic [11:0] A_US = {cta_pkg::IDX_UV_SET, 2'b00};
  localparam logic [11:0] A_ST = {cta_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_MK = {cta_pkg::IDX_MASK, 2'b00};
  localparam logic [11:0] A_AL = {cta_pkg::IDX_ALERT, 2'b00};
  // Byte lanes used by the next write; full word unless a scenario narrows it
  logic [3:0] strb = 4'hf;

  // 20 ns period
  always #10 clk = ~clk;

  cta_top uut (.CLK(clk), .RST_N(rst_n), .CUR_VALID(cur_valid), .CUR_CODE(cur_code),
    .CHARGE_CURRENT_ALERT(chg), .DISCHARGE_CURRENT_ALERT(dis), .IRQ(irq),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready),
    .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    resp = 2'h3;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= strb;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    if (!done) check(1, 0, "write timeout");
    if (!done) stop_test();
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    resp = 2'h3;
    v = 32'h0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        resp = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    if (!done) check(1, 0, "read timeout");
    if (!done) stop_test();
  endtask

  // Threshold goes in bits 15:2
  task automatic wthr(input logic [11:0] a, input logic [13:0] v);
    axi_write(a, {16'h0, v, 2'b00}, r);
    check(r, cta_pkg::RESP_OKAY, "write resp");
  endtask

  task automatic rthr(input logic [11:0] a, input logic [13:0] v);
    axi_read(a, d, r);
    check(d, {16'h0, v, 2'b00}, "read back");
    check(r, cta_pkg::RESP_OKAY, "read resp");
  endtask

  // One code, then both alerts judged a cycle later
  task automatic meas(input logic [13:0] c, input logic ec, input logic ed);
    @(posedge clk);
    cur_valid <= 1'b1;
    cur_code <= c;
    @(posedge clk);
    cur_valid <= 1'b0;
    @(negedge clk);
    check(chg, ec, "charge alert");
    check(dis, ed, "discharge alert");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    rthr(A_OC, cta_pkg::OV_THR_RESET);
    rthr(A_OS, cta_pkg::OV_THR_RESET);
    rthr(A_UC, cta_pkg::UV_THR_RESET);
    rthr(A_US, cta_pkg::UV_THR_RESET);
    meas(14'h3fff, 1'b0, 1'b0);
    meas(14'h0000, 1'b0, 1'b0);
    check(irq, 1'b0, "irq idle");
    $display("test_reset done");
  endtask

  task automatic test_regs();
    wthr(A_OC, 14'h2aaa);
    rthr(A_OC, 14'h2aaa);
    // Upper lane only: threshold bits 5:0 keep their old value
    strb = 4'h2;
    axi_write(A_OC, 32'h0000_1234, r);
    strb = 4'hf;
    rthr(A_OC, 14'h04aa);
    axi_write(A_UC, 32'hffff_ffff, r);
    check(r, cta_pkg::RESP_OKAY, "full word write");
    rthr(A_UC, 14'h3fff);
    // Unmapped place answers with an error and reads zero
    axi_write(12'h0f0, 32'h1234_5678, r);
    check(r, cta_pkg::RESP_SLVERR, "unmapped write");
    axi_read(12'h0f0, d, r);
    check(r, cta_pkg::RESP_SLVERR, "unmapped read resp");
    check(d, 32'h0, "unmapped read data");
    $display("test_regs done");
  endtask

  task automatic test_charge();
    wthr(A_UC, 14'h0000);
    wthr(A_OC, 14'h2080);
    wthr(A_OS, 14'h2100);
    meas(14'h2100, 1'b0, 1'b0);
    meas(14'h2101, 1'b1, 1'b0);
    meas(14'h20c0, 1'b1, 1'b0);
    meas(14'h2081, 1'b1, 1'b0);
    meas(14'h2080, 1'b0, 1'b0);
    // Codes on two edges in a row are each judged
    @(posedge clk);
    cur_valid <= 1'b1;
    cur_code <= 14'h2101;
    @(posedge clk);
    cur_code <= 14'h2000;
    @(negedge clk);
    check(chg, 1'b1, "first of two codes");
    @(posedge clk);
    cur_valid <= 1'b0;
    @(negedge clk);
    check(chg, 1'b0, "second of two codes");
    $display("test_charge done");
  endtask

  task automatic test_discharge();
    wthr(A_UC, 14'h1f80);
    wthr(A_US, 14'h1f00);
    meas(14'h1f00, 1'b0, 1'b0);
    meas(14'h1eff, 1'b0, 1'b1);
    meas(14'h1f7f, 1'b0, 1'b1);
    meas(14'h1f80, 1'b0, 1'b0);
    meas(14'h0000, 1'b0, 1'b1);
    axi_read(A_AL, d, r);
    check(d, 32'ha, "alert view discharging");
    meas(14'h2000, 1'b0, 1'b0);
    axi_read(A_AL, d, r);
    check(d, 32'h0, "alert view at zero");
    $display("test_discharge done");
  endtask

  task automatic test_irq();
    axi_write(A_ST, 32'h3, r);
    axi_read(A_ST, d, r);
    check(d, 32'h0, "status cleared");
    axi_write(A_MK, 32'h1, r);
    meas(14'h2101, 1'b1, 1'b0);
    check(irq, 1'b1, "irq unmasked");
    // Alert view is read-only: write accepted and dropped
    axi_write(A_AL, 32'h0000_000f, r);
    check(r, cta_pkg::RESP_OKAY, "alert view write");
    axi_read(A_AL, d, r);
    check(d, 32'h5, "alert view charging");
    axi_write(A_ST, 32'h1, r);
    @(negedge clk);
    check(irq, 1'b0, "irq after clear");
    // Discharge event is masked, so the line stays low
    meas(14'h1eff, 1'b0, 1'b1);
    check(irq, 1'b0, "irq masked");
    axi_read(A_ST, d, r);
    check(d, 32'h2, "status discharge");
    $display("test_irq done");
  endtask

  // Reset in mid-run brings the discharge alert, IRQ, both set thresholds and mask back to defaults
  task automatic test_reset_mid();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(dis, 1'b0, "alert after reset");
    check(irq, 1'b0, "irq after reset");
    rthr(A_OS, cta_pkg::OV_THR_RESET);
    rthr(A_US, cta_pkg::UV_THR_RESET);
    axi_read(A_MK, d, r);
    check(d, 32'h0, "mask after reset");
    $display("test_reset_mid done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_regs();
    test_charge();
    test_discharge();
    test_irq();
    test_reset_mid();
    stop_test();
  end
endmodule
